// ===== ldorc_pkg.sv
// constants, field layouts and carrier types of the regulator control bank
// assumes one 125 MHz clock and an AXI4-Lite master in front of the bank
package ldorc_pkg;

    // ****************************************
    // map: printed offsets are indices, byte address is four times
    // ****************************************
    localparam int         NLDO                = 3;
    localparam logic [7:0] IDX_VSEL [0:NLDO-1] = '{8'h50, 8'h54, 8'h60};
    localparam logic [7:0] IDX_CTRL [0:NLDO-1] = '{8'h51, 8'h55, 8'h61};
    localparam logic [7:0] IDX_IRQ_STS         = 8'h68;
    localparam logic [7:0] IDX_IRQ_MSK         = 8'h69;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int         VCODE_W     = 6;
    localparam int         CTL_EN      = 7;
    localparam int         CTL_DISCHARGE = 6;
    localparam int         CTL_LOWQ    = 5;
    localparam int         CTL_DLY_LSB = 2;
    localparam int         CTL_ALLOW   = 1;
    localparam int         CTL_OK      = 0;
    localparam int         IRQ_W       = 6;
    localparam int         IRQ_FAULT   = 0;
    localparam int         IRQ_PGLOST  = 3;
    localparam logic [5:0] RST_VCODE   = 6'h00;
    localparam logic [6:0] RST_CTRL    = 7'h00;
    localparam logic [5:0] RST_IRQ     = 6'h00;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_PS = 8000;
    localparam int DLY_STEP_NS   = 1000;
    localparam int DLY_STEP_CYC  = (DLY_STEP_NS * 1000) / CLK_PERIOD_PS;
    localparam int DLY_CNT_W     = 24;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic                 en;
        logic                 shutdown_discharge_en;
        logic                 lowq;
        logic [2:0]           dly;
        logic                 allow;
        logic [VCODE_W-1:0]   vcode;
    } ldorc_cfg_s;

    typedef struct packed {
        logic                 on;
        logic                 discharge;
        logic                 lowq;
        logic [VCODE_W-1:0]   vcode;
    } ldorc_out_s;

    typedef enum logic [1:0] {ST_OFF, ST_WAIT, ST_ON} ldorc_st_e;

endpackage

// ===== ldorc_regs.sv
// register bank and sequencing of three low-dropout regulators
// assumes AXI4-Lite master, synchronous analog status inputs
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ldorc_regs #(
    parameter logic [23:0] DLY_LUT [0:7] = '{
        24'h00_0000, 24'(1 * ldorc_pkg::DLY_STEP_CYC),
        24'(2 * ldorc_pkg::DLY_STEP_CYC), 24'(4 * ldorc_pkg::DLY_STEP_CYC),
        24'(8 * ldorc_pkg::DLY_STEP_CYC), 24'(16 * ldorc_pkg::DLY_STEP_CYC),
        24'(32 * ldorc_pkg::DLY_STEP_CYC), 24'(64 * ldorc_pkg::DLY_STEP_CYC)}
) (
    input  wire logic                          clk_sys,
    input  wire logic                          rst_b,
    input  wire logic [11:0]                   s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output logic                               s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output logic                               s_axi_wready,
    output logic [1:0]                         s_axi_bresp,
    output logic                               s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [11:0]                   s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output logic                               s_axi_arready,
    output logic [31:0]                        s_axi_rdata,
    output logic [1:0]                         s_axi_rresp,
    output logic                               s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    input  wire logic [2:0]                    power_good,
    input  wire logic [2:0]                    fault,
    output ldorc_pkg::ldorc_out_s [2:0]        ldo_out,
    output logic                               irq
);

    // ****************************************
    // address decode
    // ****************************************
    function automatic logic ldorc_hit(input logic [11:0] a);
        logic h;
        h = (a[1:0] == 2'h0) && (a[11:10] == 2'h0);
        h = h && ((a[9:2] == ldorc_pkg::IDX_IRQ_STS) ||
                  (a[9:2] == ldorc_pkg::IDX_IRQ_MSK) ||
                  (a[9:2] == ldorc_pkg::IDX_VSEL[0]) ||
                  (a[9:2] == ldorc_pkg::IDX_VSEL[1]) ||
                  (a[9:2] == ldorc_pkg::IDX_VSEL[2]) ||
                  (a[9:2] == ldorc_pkg::IDX_CTRL[0]) ||
                  (a[9:2] == ldorc_pkg::IDX_CTRL[1]) ||
                  (a[9:2] == ldorc_pkg::IDX_CTRL[2]));
        return h;
    endfunction

    ldorc_pkg::ldorc_cfg_s [2:0]  cfg_q;
    ldorc_pkg::ldorc_out_s [2:0]  out_q;
    logic [5:0]                   sts_q;
    logic [5:0]                   msk_q;
    logic [5:0]                   ev;
    logic [2:0]                   pg_q;
    logic                         irq_q;
    logic                         aw_q;
    logic                         w_q;
    logic [11:0]                  awaddr_q;
    logic [31:0]                  wdata_q;
    logic [3:0]                   wstrb_q;
    logic                         bvalid_q;
    logic [1:0]                   bresp_q;
    logic                         rvalid_q;
    logic [1:0]                   rresp_q;
    logic [31:0]                  rdata_q;
    logic [31:0]                  rd_val;
    logic                         do_wr;
    logic                         wr_lane0;
    logic [7:0]                   wr_idx;
    logic                         ar_fire;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // ****************************************
    // write channel
    // ****************************************
    // address and data are taken in either order; response after both
    assign s_axi_awready = !aw_q && !bvalid_q;
    assign s_axi_wready  = !w_q && !bvalid_q;
    assign do_wr         = aw_q && w_q;
    assign wr_idx        = awaddr_q[9:2];
    assign wr_lane0      = do_wr && wstrb_q[0] && ldorc_hit(awaddr_q);
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            aw_q     <= 1'b0;
            awaddr_q <= 12'h000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (do_wr) begin
            aw_q     <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            w_q     <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end else if (do_wr) begin
            w_q     <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            bvalid_q <= 1'b0;
            bresp_q  <= ldorc_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid_q <= 1'b1;
            bresp_q  <= ldorc_hit(awaddr_q) ? ldorc_pkg::RESP_OKAY
                                            : ldorc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    assign s_axi_arready = !rvalid_q;
    assign ar_fire       = s_axi_arvalid && !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    always_comb begin
        rd_val = 32'h0000_0000;
        for (int i = 0; i < ldorc_pkg::NLDO; i++) begin
            if (s_axi_araddr[9:2] == ldorc_pkg::IDX_VSEL[i]) begin
                rd_val[ldorc_pkg::VCODE_W-1:0] = cfg_q[i].vcode;
            end
            if (s_axi_araddr[9:2] == ldorc_pkg::IDX_CTRL[i]) begin
                rd_val[7:1]              = cfg_q[i][12:6];
                rd_val[ldorc_pkg::CTL_OK] = power_good[i];
            end
        end
        if (s_axi_araddr[9:2] == ldorc_pkg::IDX_IRQ_STS) begin
            rd_val[5:0] = sts_q;
        end
        if (s_axi_araddr[9:2] == ldorc_pkg::IDX_IRQ_MSK) begin
            rd_val[5:0] = msk_q;
        end
        if (!ldorc_hit(s_axi_araddr)) begin
            rd_val = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rvalid_q <= 1'b0;
            rresp_q  <= ldorc_pkg::RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_val;
            rresp_q  <= ldorc_hit(s_axi_araddr) ? ldorc_pkg::RESP_OKAY
                                                : ldorc_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ****************************************
    // per-regulator configuration and sequencing
    // ****************************************
    for (genvar i = 0; i < ldorc_pkg::NLDO; i++) begin : g_ldo
        ldorc_pkg::ldorc_st_e  st_q;
        logic [23:0]           cnt_q;
        logic                  on_d;

        always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
                cfg_q[i].vcode <= ldorc_pkg::RST_VCODE;
            end else if (wr_lane0 && wr_idx == ldorc_pkg::IDX_VSEL[i]) begin
                cfg_q[i].vcode <= wdata_q[ldorc_pkg::VCODE_W-1:0];
            end
        end

        // bit 0 of the written byte is dropped: power-good is read-only
        always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
                cfg_q[i][12:6] <= ldorc_pkg::RST_CTRL;
            end else if (wr_lane0 && wr_idx == ldorc_pkg::IDX_CTRL[i]) begin
                cfg_q[i][12:6] <= wdata_q[7:1];
            end
        end

        // turning off is immediate; turning on waits the table delay
        always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
                st_q  <= ldorc_pkg::ST_OFF;
                cnt_q <= 24'h00_0000;
            end else begin
                unique case (st_q)
                    ldorc_pkg::ST_OFF: begin
                        if (cfg_q[i].en) begin
                            st_q  <= ldorc_pkg::ST_WAIT;
                            cnt_q <= DLY_LUT[cfg_q[i].dly];
                        end
                    end
                    ldorc_pkg::ST_WAIT: begin
                        if (!cfg_q[i].en) begin
                            st_q <= ldorc_pkg::ST_OFF;
                        end else if (cnt_q == 24'h00_0000) begin
                            st_q <= ldorc_pkg::ST_ON;
                        end else begin
                            cnt_q <= cnt_q - 24'h00_0001;
                        end
                    end
                    ldorc_pkg::ST_ON: begin
                        if (!cfg_q[i].en) begin
                            st_q <= ldorc_pkg::ST_OFF;
                        end
                    end
                endcase
            end
        end

        assign on_d = cfg_q[i].en && ((st_q == ldorc_pkg::ST_ON) ||
                      (st_q == ldorc_pkg::ST_WAIT && cnt_q == 24'h00_0000));

        always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
                out_q[i] <= '0;
            end else begin
                out_q[i].on        <= on_d;
                out_q[i].discharge <= cfg_q[i].shutdown_discharge_en && !on_d;
                out_q[i].lowq      <= cfg_q[i].lowq;
                out_q[i].vcode     <= cfg_q[i].vcode;
            end
        end

        assign ev[ldorc_pkg::IRQ_FAULT + i]  = fault[i] && cfg_q[i].allow;
        assign ev[ldorc_pkg::IRQ_PGLOST + i] = pg_q[i] && !power_good[i];

        sequence s_go;
            st_q == ldorc_pkg::ST_WAIT && cnt_q == 24'h00_0000 && cfg_q[i].en;
        endsequence
        sequence s_vwr;
            wr_lane0 && wr_idx == ldorc_pkg::IDX_VSEL[i];
        endsequence

        property p_vcode;
            s_vwr |=> ##1 out_q[i].vcode == $past(wdata_q[5:0], 2);
        endproperty
        a_vcode: assert property (p_vcode) else $error("voltage code lost");

        property p_off;
            !cfg_q[i].en |=> !out_q[i].on;
        endproperty
        a_off: assert property (p_off) else $error("regulator on while disabled");

        property p_dis;
            (st_q == ldorc_pkg::ST_OFF && cfg_q[i].shutdown_discharge_en && !cfg_q[i].en)
                |=> out_q[i].discharge && !out_q[i].on;
        endproperty
        a_dis: assert property (p_dis) else $error("no discharge in shutdown");

        property p_lowq;
            $changed(cfg_q[i].lowq) |=> out_q[i].lowq == $past(cfg_q[i].lowq);
        endproperty
        a_lowq: assert property (p_lowq) else $error("low-q mode not applied");

        property p_go;
            s_go |=> out_q[i].on && st_q == ldorc_pkg::ST_ON;
        endproperty
        a_go: assert property (p_go) else $error("turn-on after delay missed");

        property p_wait;
            st_q == ldorc_pkg::ST_WAIT && cnt_q != 24'h00_0000 |=> !out_q[i].on;
        endproperty
        a_wait: assert property (p_wait) else $error("turned on during delay");

        property p_allow;
            $rose(sts_q[ldorc_pkg::IRQ_FAULT + i])
                |-> $past(fault[i] && cfg_q[i].allow);
        endproperty
        a_allow: assert property (p_allow) else $error("masked fault flagged");

        property p_ok;
            ar_fire && s_axi_araddr[9:2] == ldorc_pkg::IDX_CTRL[i]
                && ldorc_hit(s_axi_araddr) |=> rdata_q[0] == $past(power_good[i]);
        endproperty
        a_ok: assert property (p_ok) else $error("power-good read wrong");
    end

    assign ldo_out = out_q;

    // ****************************************
    // interrupt status, mask and output
    // ****************************************
    // set wins over a same-cycle write-one-to-clear
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sts_q <= ldorc_pkg::RST_IRQ;
        end else if (wr_lane0 && wr_idx == ldorc_pkg::IDX_IRQ_STS) begin
            sts_q <= (sts_q & ~wdata_q[5:0]) | ev;
        end else begin
            sts_q <= sts_q | ev;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            msk_q <= ldorc_pkg::RST_IRQ;
        end else if (wr_lane0 && wr_idx == ldorc_pkg::IDX_IRQ_MSK) begin
            msk_q <= wdata_q[5:0];
        end
    end

    // edge memory for power-good loss; starts low so reset is no event
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pg_q <= 3'h0;
        end else begin
            pg_q <= power_good;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(sts_q & msk_q);
        end
    end

    assign irq = irq_q;

    property p_bresp;
        do_wr |=> s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response missing");

    property p_irq;
        $rose(irq) |-> $past(|(sts_q & msk_q));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt without cause");

endmodule // ldorc_regs
`default_nettype wire

// ===== ldo_regulator_control_regs_tb.sv
// self-checking bench for the regulator control bank, driven over axi4-lite
// assumes a single 125 MHz clock and a shortened turn-on delay table
`timescale 1ns/1ps
`default_nettype none
module ldo_regulator_control_regs_tb;
    // ****************************************
    // signals
    // ****************************************
    localparam logic [23:0] LUT [0:7] = '{24'h00_0000, 24'h00_0008, 24'h00_0010,
        24'h00_0018, 24'h00_0020, 24'h00_0028, 24'h00_0030, 24'h00_0038};
    localparam logic [11:0] STS = 12'h01A0;
    localparam logic [11:0] MSK = 12'h01A4;
    logic                         clk_sys;
    logic                         rst_b;
    logic [11:0]                  s_axi_awaddr, s_axi_araddr;
    logic                         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic [31:0]                  s_axi_wdata, s_axi_rdata;
    logic [3:0]                   s_axi_wstrb;
    logic [1:0]                   s_axi_bresp, s_axi_rresp;
    logic                         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                         s_axi_rvalid, s_axi_rready, irq;
    logic [2:0]                   power_good, fault;
    ldorc_pkg::ldorc_out_s [2:0]  ldo_out;
    int                           errors, checks_done;

    ldorc_regs #(.DLY_LUT(LUT)) u_ldorc_regs (
        .clk_sys(clk_sys), .rst_b(rst_b),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .power_good(power_good), .fault(fault),
        .ldo_out(ldo_out), .irq(irq));

    // ****************************************
    // bus tasks
    // ****************************************
    // handshakes are read right after the edge, before the bank's own updates land
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r,
        input logic [3:0] s = 4'hF);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 100);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 100);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", s, exp, seen);
        end
    endtask

    task automatic wrc(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        chk("write resp", 32'(r), 32'(ldorc_pkg::RESP_OKAY));
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string s);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(s, d, e);
        chk("read resp", 32'(r), 32'(ldorc_pkg::RESP_OKAY));
    endtask

    function automatic logic [11:0] va(input int i);
        return {2'b00, ldorc_pkg::IDX_VSEL[i], 2'b00};
    endfunction

    function automatic logic [11:0] ca(input int i);
        return {2'b00, ldorc_pkg::IDX_CTRL[i], 2'b00};
    endfunction

    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // clock, watchdog, tests
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // whole run is a few hundred cycles; this is far beyond it
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        close_out();
    end

    initial begin
        logic [2:0]  d;
        logic [31:0] rv;
        logic [1:0]  r;
        int          n;
        {rst_b, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        power_good = 3'b000;
        fault = 3'b000;
        errors = 0;
        checks_done = 0;
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            rdc(va(i), 32'h0000_0000, "vsel reset");
            rdc(ca(i), 32'h0000_0000, "ctrl reset");
            wrc(va(i), 32'h0000_00FF);
            rdc(va(i), 32'h0000_003F, "vsel rw");
            chk("vcode out", 32'(ldo_out[i].vcode), 32'h0000_003F);
            d = 3'(2 * i + 1);
            wrc(ca(i), {24'h00_0000, 3'b011, d, 2'b11});
            rdc(ca(i), {24'h00_0000, 3'b011, d, 2'b10}, "ctrl rw");
            chk("off", 32'(ldo_out[i].on), 32'h0000_0000);
            chk("discharge", 32'(ldo_out[i].discharge), 32'h0000_0001);
            chk("lowq", 32'(ldo_out[i].lowq), 32'h0000_0001);
        end
        rdc(STS, 32'h0000_0000, "status reset");
        rdc(MSK, 32'h0000_0000, "mask reset");
        power_good <= 3'b111;
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i < 3; i++) begin
            d = 3'(2 * i + 1);
            rdc(ca(i), {24'h00_0000, 3'b011, d, 2'b11}, "power good");
            wrc(ca(i), {24'h00_0000, 3'b111, d, 2'b10});
            n = 0;
            while (ldo_out[i].on !== 1'b1 && n < 200) begin
                @(posedge clk_sys);
                n++;
            end
            // the table step is 8 cycles, so this window tells codes apart
            chk("turn-on delay", 32'(n >= int'(LUT[d]) - 1 && n <= int'(LUT[d]) + 3), 1);
            repeat (2) @(posedge clk_sys);
            chk("discharge when on", 32'(ldo_out[i].discharge), 32'h0000_0000);
            wrc(ca(i), {24'h00_0000, 3'b010, d, 2'b10});
            repeat (2) @(posedge clk_sys);
            chk("turned off", 32'(ldo_out[i].on), 32'h0000_0000);
            chk("discharge off", 32'(ldo_out[i].discharge), 32'h0000_0001);
            chk("normal mode", 32'(ldo_out[i].lowq), 32'h0000_0000);
            rdc(ca(i), {24'h00_0000, 3'b010, d, 2'b11}, "ctrl off");
        end
        // fault blocked, then allowed, masked and cleared
        wrc(MSK, 32'h0000_003F);
        wrc(ca(0), {24'h00_0000, 3'b010, 3'b001, 2'b00});
        fault <= 3'b001;
        repeat (3) @(posedge clk_sys);
        fault <= 3'b000;
        repeat (2) @(posedge clk_sys);
        chk("irq blocked", 32'(irq), 32'h0000_0000);
        rdc(STS, 32'h0000_0000, "blocked fault");
        wrc(ca(0), {24'h00_0000, 3'b010, 3'b001, 2'b10});
        fault <= 3'b001;
        repeat (3) @(posedge clk_sys);
        fault <= 3'b000;
        repeat (2) @(posedge clk_sys);
        chk("irq raised", 32'(irq), 32'h0000_0001);
        rdc(STS, 32'h0000_0001, "fault status");
        wrc(MSK, 32'h0000_0000);
        repeat (2) @(posedge clk_sys);
        chk("irq masked", 32'(irq), 32'h0000_0000);
        wrc(MSK, 32'h0000_003F);
        wrc(STS, 32'h0000_0001);
        repeat (2) @(posedge clk_sys);
        chk("irq cleared", 32'(irq), 32'h0000_0000);
        rdc(STS, 32'h0000_0000, "status cleared");
        power_good <= 3'b000;
        repeat (3) @(posedge clk_sys);
        rdc(STS, 32'h0000_0038, "power lost");
        rdc(ca(1), {24'h00_0000, 3'b010, 3'b011, 2'b10}, "power low");
        wrc(STS, 32'h0000_0038);
        rdc(STS, 32'h0000_0000, "lost cleared");
        // unmapped and unaligned places answer with an error
        // upper address bits set over a real index: must not alias onto it
        wr(12'h940, 32'h0000_0000, r);
        chk("unmapped write", 32'(r), 32'(ldorc_pkg::RESP_SLVERR));
        // low byte strobe off: accepted but dropped
        wr(va(0), 32'h0000_0000, r, 4'hE);
        chk("no-strobe write", 32'(r), 32'(ldorc_pkg::RESP_OKAY));
        rd(12'h142, rv, r);
        chk("unaligned read", 32'(r), 32'(ldorc_pkg::RESP_SLVERR));
        chk("unaligned data", rv, 32'h0000_0000);
        rdc(va(0), 32'h0000_003F, "vsel kept");
        close_out();
    end
endmodule // ldo_regulator_control_regs_tb
`default_nettype wire
